// ===== core/tlih_top.sv
/*
  Two-level interrupt handler with an AHB-Lite register slave.
  Assumes peripherals pulse src_event on hclk, and the core pulses
  insn_done at each instruction end and return_from_interrupt_done when a return completes.
*/
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module tlih_top
  import tlih_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [tlih_pkg::NSRC-1:0] src_event,
  input wire logic insn_done,
  input wire logic return_from_interrupt_done,
  output logic req_pending,
  output logic call_pulse,
  output logic [15:0] call_vector,
  output logic [tlih_pkg::IDXW-1:0] call_src,
  output logic [tlih_pkg::NSRC-1:0] pending
);
  import tlih_pkg::*;

  logic [7:0] ie_r;
  logic [7:0] ie_nxt;
  logic [NEXT-1:0] eie_r;
  logic [NEXT-1:0] eie_nxt;
  logic [NSRC-1:0] prio_r;
  logic [NSRC-1:0] prio_nxt;
  logic [NSRC-1:0] auto_r;
  logic [NSRC-1:0] auto_nxt;
  logic [NSRC-1:0] pend_r;
  logic [NSRC-1:0] pend_nxt;
  logic [NSRC-1:0] sw_set;
  logic [NSRC-1:0] sw_clr;
  logic [NSRC-1:0] hw_clr;
  logic [NSRC-1:0] en_all;
  logic [NSRC-1:0] live;
  logic [NSRC-1:0] live_hi;
  logic [NSRC-1:0] live_lo;
  logic in_low_r;
  logic in_high_r;
  logic hold_r;
  logic hi_found;
  logic lo_found;
  logic [IDXW-1:0] hi_idx;
  logic [IDXW-1:0] lo_idx;
  logic take;
  logic take_hi;
  logic [IDXW-1:0] take_idx;
  logic dph_wr_r;
  logic [7:0] dph_addr_r;
  logic wr_ie;
  logic wr_eie;
  logic wr_prio;
  logic wr_pend;
  logic wr_clr;
  logic wr_auto;
  logic addr_ok;
  logic rd_hit;
  logic [31:0] rd_nxt;
  logic req_nxt;

  // exact 8-bit match of a register byte address
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
    is_reg = (a == r);
  endfunction

  // --- AHB-Lite address phase capture ---
  assign addr_ok = hsel && hready &&
    (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
    end
    else
    begin
      dph_wr_r <= addr_ok && hwrite;
      if (addr_ok)
        dph_addr_r <= haddr[7:0];
    end
  end

  // never stalls, never errors
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // write strobes act in the data phase
  assign wr_ie = dph_wr_r && is_reg(dph_addr_r, ADDR_IE);
  assign wr_eie = dph_wr_r && is_reg(dph_addr_r, ADDR_EIE);
  assign wr_prio = dph_wr_r && is_reg(dph_addr_r, ADDR_PRIO);
  assign wr_pend = dph_wr_r && is_reg(dph_addr_r, ADDR_PEND);
  assign wr_clr = dph_wr_r && is_reg(dph_addr_r, ADDR_CLR);
  assign wr_auto = dph_wr_r && is_reg(dph_addr_r, ADDR_AUTO);

  assign ie_nxt = wr_ie ? hwdata[7:0] : ie_r;
  assign eie_nxt = wr_eie ? hwdata[NEXT-1:0] : eie_r;
  assign prio_nxt = wr_prio ? hwdata[NSRC-1:0] : prio_r;
  assign auto_nxt = wr_auto ? hwdata[NSRC-1:0] : auto_r;

  // (RQ6) per-source enables in two registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ie_r <= IE_RST;
      eie_r <= '0;
      prio_r <= '0;
      auto_r <= AUTO_RST;
    end
    else
    begin
      ie_r <= ie_nxt;
      eie_r <= eie_nxt;
      prio_r <= prio_nxt;
      auto_r <= auto_nxt;
    end
  end

  // --- pending flags ---
  // (RQ10) software set behaves as an event
  assign sw_set = wr_pend ? hwdata[NSRC-1:0] : '0;
  assign sw_clr = wr_clr ? hwdata[NSRC-1:0] : '0;

  // (RQ8) auto-clear only the vectored source, if marked
  generate
    for (genvar g = 0; g < NSRC; g++)
    begin : g_hwclr
      assign hw_clr[g] = take && (take_idx == IDXW'(g)) && auto_r[g];
    end
  endgenerate

  // (RQ2) events set flags; set wins over any clear
  // (RQ3) setting ignores the enables
  assign pend_nxt = (pend_r & ~sw_clr & ~hw_clr) | src_event | sw_set;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend_r <= '0;
    else
      pend_r <= pend_nxt;
  end

  // --- request qualification ---
  // (RQ7) global enable gates every source
  assign en_all = ie_r[GIE_BIT] ? {eie_r, ie_r[NLOW-1:0]} : '0;
  // (RQ3) disabled flags are ignored
  assign live = pend_r & en_all;

  // (RQ11) high preempts low; neither nests on itself
  assign live_hi = in_high_r ? '0 : (live & prio_r);
  assign live_lo = (in_high_r || in_low_r) ? '0 : (live & ~prio_r);

  // (RQ1) (RQ11) lowest index wins within a level
  tlih_pick u_pick_hi
  (
    .req(live_hi),
    .found(hi_found),
    .idx(hi_idx)
  );

  tlih_pick u_pick_lo
  (
    .req(live_lo),
    .found(lo_found),
    .idx(lo_idx)
  );

  assign req_nxt = hi_found || lo_found;
  assign take_hi = hi_found;
  assign take_idx = hi_found ? hi_idx : lo_idx;

  // (RQ4) vector only at an instruction boundary
  // (RQ9) one instruction must pass after a return
  assign take = req_nxt && insn_done && !hold_r;

  // (RQ9) hold across the first instruction after return
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_r <= 1'b0;
    else if (return_from_interrupt_done)
      hold_r <= 1'b1;
    else if (insn_done)
      hold_r <= 1'b0;
  end

  // (RQ5) return pops the innermost active level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      in_low_r <= 1'b0;
      in_high_r <= 1'b0;
    end
    else if (take)
    begin
      if (take_hi)
        in_high_r <= 1'b1;
      else
        in_low_r <= 1'b1;
    end
    else if (return_from_interrupt_done)
    begin
      if (in_high_r)
        in_high_r <= 1'b0;
      else
        in_low_r <= 1'b0;
    end
  end

  // (RQ4) long_call target, one pulse per vector
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      call_pulse <= 1'b0;
      call_vector <= VEC_BASE;
      call_src <= '0;
    end
    else
    begin
      call_pulse <= take;
      if (take)
      begin
        call_src <= take_idx;
        call_vector <= VEC_BASE + (16'(take_idx) << VEC_SHIFT);
      end
    end
  end

  // (RQ9) request is raised at once, even while held
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_pending <= 1'b0;
      pending <= '0;
    end
    else
    begin
      req_pending <= req_nxt;
      pending <= pend_nxt;
    end
  end

  // --- read path: next values so back-to-back write/read is coherent ---
  always_comb
  begin
    rd_nxt = '0;
    rd_hit = addr_ok && !hwrite;
    if (rd_hit)
    begin
      case (haddr[7:0])
        ADDR_IE: rd_nxt = {24'h000000, ie_nxt};
        ADDR_EIE: rd_nxt = {26'h0000000, eie_nxt};
        ADDR_PRIO: rd_nxt = {19'h00000, prio_nxt};
        ADDR_PEND: rd_nxt = {19'h00000, pend_nxt};
        ADDR_AUTO: rd_nxt = {19'h00000, auto_nxt};
        ADDR_STAT: rd_nxt = {24'h000000, req_nxt, hold_r,
          in_high_r, in_low_r, take_idx};
        default: rd_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else
      hrdata <= rd_nxt;
  end

  // hsize unused: only whole-word transfers are supported
  logic unused_size;
  assign unused_size = ^hsize;
endmodule

// ===== core/tlih_pkg.sv
/*
  Constants, register map and types for the two-level interrupt handler.
  Assumes one 40 MHz clock shared by the bus, the core and the peripherals.
*/
// Contract
// (RQ1) Thirteen interrupt sources are handled, each at one of two priority levels.
// (RQ2) A source event sets that source's pending flag to one.
// (RQ3) Flags set even when disabled, and a disabled flag makes no request.
// (RQ4) An enabled pending flag raises a request and a long_call follows the current instruction.
// (RQ5) Each routine ends with return_from_interrupt, which resumes the interrupted flow.
// (RQ6) Every source has its own enable bit in interrupt_enable_reg or extended_enable_reg.
// (RQ7) Bit 7 of interrupt_enable_reg, global_interrupt_enable, must be one for any source to pass.
// (RQ8) Selected flags are cleared by hardware on the vector; the rest are cleared by software.
// (RQ9) A flag still set after return_from_interrupt re-enters only after one more instruction.
// (RQ10) Software writing a pending flag to one acts just like a hardware event.
// (RQ11) High priority preempts low; at equal level the lower source index wins.
package tlih_pkg;
  localparam int NSRC = 13;
  localparam int IDXW = 4;
  localparam int NLOW = 7;
  localparam int NEXT = 6;
  localparam int GIE_BIT = 7;
  localparam int VEC_SHIFT = 3;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  // byte addresses
  localparam logic [7:0] ADDR_IE = 8'h00;
  localparam logic [7:0] ADDR_EIE = 8'h04;
  localparam logic [7:0] ADDR_PRIO = 8'h08;
  localparam logic [7:0] ADDR_PEND = 8'h0c;
  localparam logic [7:0] ADDR_CLR = 8'h10;
  localparam logic [7:0] ADDR_AUTO = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] IE_RST = 8'h00;
  localparam logic [NSRC-1:0] AUTO_RST = 13'h0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  typedef enum logic [1:0] {TLIH_LVL_NONE, TLIH_LVL_LOW, TLIH_LVL_HIGH}
    tlih_lvl_t;
endpackage

// ===== core/tlih_pick.sv
/*
  Fixed-order picker: finds the lowest set bit of a request vector.
  Assumes a purely combinational use inside the handler.
*/
`timescale 1ns/100ps
module tlih_pick
  import tlih_pkg::*;
(
  input wire logic [tlih_pkg::NSRC-1:0] req,
  output logic found,
  output logic [tlih_pkg::IDXW-1:0] idx
);
  // top-down scan so the lowest index is assigned last and wins
  always_comb
  begin
    found = 1'b0;
    idx = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx = IDXW'(i);
      end
    end
  end
endmodule

// ===== verif/tlih_top_checker.sv
/*
  Port assertions for the interrupt handler.
  Assumes one clock domain; bound into tlih_top below.
*/
`timescale 1ns/100ps
module tlih_top_checker
  import tlih_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [tlih_pkg::NSRC-1:0] src_event,
  input wire logic insn_done,
  input wire logic return_from_interrupt_done,
  input wire logic req_pending,
  input wire logic call_pulse,
  input wire logic [15:0] call_vector,
  input wire logic [tlih_pkg::IDXW-1:0] call_src,
  input wire logic [tlih_pkg::NSRC-1:0] pending
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_call_at_end: assert property (
    call_pulse |-> $past(insn_done)) else $error("call off boundary");
  a_vec_map: assert property (
    call_pulse |-> call_vector == VEC_BASE + (16'(call_src) << VEC_SHIFT))
    else $error("wrong vector");
  a_src_range: assert property (
    call_pulse |-> call_src < 4'(NSRC)) else $error("source out of range");
  a_call_flag: assert property (
    call_pulse |-> (($past(pending) >> call_src) & 13'h1) != 13'h0)
    else $error("call without flag");
  a_no_flag_idle: assert property (
    $past(pending) == '0 |-> !req_pending) else $error("request w/o flag");
  a_flag_set: assert property (
    src_event != '0 |=> (pending & $past(src_event)) == $past(src_event))
    else $error("flag not set");
  a_return_from_interrupt_hold: assert property (
    $past(return_from_interrupt_done, 2) |-> !call_pulse) else $error("call too soon");
  a_vec_holds: assert property (
    !call_pulse |-> $stable(call_vector) && $stable(call_src))
    else $error("vector moved");
endmodule

bind tlih_top tlih_top_checker u_chk (.hclk, .hresetn, .src_event,
  .insn_done, .return_from_interrupt_done, .req_pending, .call_pulse, .call_vector,
  .call_src, .pending);

// ===== verif/tlih_core_model.sv
/*
  Core sequencer model: ends instructions, returns, takes calls.
  Assumes the bench commands run and ret on hclk.
*/
`timescale 1ns/100ps
module tlih_core_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic ret,
  input wire logic call_pulse,
  input wire logic [15:0] call_vector,
  output logic insn_done,
  output logic return_from_interrupt_done,
  output logic [7:0] call_cnt,
  output logic [15:0] last_vec
);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      insn_done <= 1'b0;
      return_from_interrupt_done <= 1'b0;
    end
    else
    begin
      insn_done <= run;
      return_from_interrupt_done <= ret;
    end
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      call_cnt <= 8'h00;
      last_vec <= 16'h0000;
    end
    else if (call_pulse)
    begin
      call_cnt <= call_cnt + 8'h01;
      last_vec <= call_vector;
    end
endmodule

// ===== verif/tb_two_level_interrupt_handler.sv
/*
  Self-checking bench for tlih_top.
  Assumes the core model in place of the instruction sequencer.
*/
`timescale 1ns/100ps
module tb_two_level_interrupt_handler;
  import tlih_pkg::*;
  typedef struct packed {logic [7:0] ie; logic [7:0] eie;
    logic [3:0] src; logic hit;} tlih_row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NSRC-1:0] src_event, pending;
  logic insn_done, return_from_interrupt_done, req_pending, call_pulse, run, ret;
  logic [15:0] call_vector, last_vec;
  logic [IDXW-1:0] call_src;
  logic [7:0] call_cnt, n0;
  int err_total, check_count;
  tlih_row_t rows [6];
  assign hready = hreadyout;
  tlih_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .src_event, .insn_done,
    .return_from_interrupt_done, .req_pending, .call_pulse, .call_vector, .call_src,
    .pending);
  tlih_core_model core (.hclk, .hresetn, .run, .ret, .call_pulse,
    .call_vector, .insn_done, .return_from_interrupt_done, .call_cnt, .last_vec);
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // one instruction end, then let the call land
  task automatic step();
    @(posedge hclk);
    run <= 1'b1;
    @(posedge hclk);
    run <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic ret_pulse();
    @(posedge hclk);
    ret <= 1'b1;
    @(posedge hclk);
    ret <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    finish_test();
  end
  initial
  begin
    {hresetn, hsel, hwrite, run, ret} = 5'h08;
    {haddr, hwdata, htrans, src_event} = '0;
    hsize = 3'h2;
    rows = '{'{8'h84, 8'h00, 4'h2, 1'b1}, '{8'h04, 8'h00, 4'h2, 1'b0},
      '{8'h80, 8'h00, 4'h2, 1'b0}, '{8'h80, 8'h20, 4'hc, 1'b1},
      '{8'hc0, 8'h00, 4'h6, 1'b1}, '{8'h80, 8'h01, 4'h7, 1'b1}};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      xfer(1'b1, ADDR_IE, {24'h0, rows[i].ie});
      xfer(1'b1, ADDR_EIE, {24'h0, rows[i].eie});
      n0 = call_cnt;
      @(posedge hclk);
      src_event <= 13'h1 << rows[i].src;
      @(posedge hclk);
      src_event <= '0;
      step();
      step();
      chk("flag", 32'h1, 32'(pending[rows[i].src]));
      chk("calls", 32'(rows[i].hit), 32'(call_cnt - n0));
      if (rows[i].hit)
        chk("vec", 32'h3 + 32'h8 * rows[i].src, 32'(last_vec));
      xfer(1'b1, ADDR_CLR, 32'h1 << rows[i].src);
      ret_pulse();
      $display("row %0d done", i);
    end
    step();
    xfer(1'b1, ADDR_IE, 32'h81);
    xfer(1'b1, ADDR_EIE, 32'h0);
    n0 = call_cnt;
    xfer(1'b1, ADDR_PEND, 32'h1);
    step();
    chk("sw set", 32'h1, 32'(call_cnt - n0));
    ret_pulse();
    // pop lands one edge late; read after the request register settles
    repeat (3) @(posedge hclk);
    chk("req", 32'h1, 32'(req_pending));
    step();
    chk("held", 32'h1, 32'(call_cnt - n0));
    step();
    chk("reenter", 32'h2, 32'(call_cnt - n0));
    $display("reentry done");
    xfer(1'b1, ADDR_CLR, 32'h1);
    ret_pulse();
    step();
    xfer(1'b1, ADDR_AUTO, 32'h1);
    xfer(1'b1, ADDR_IE, 32'h83);
    n0 = call_cnt;
    xfer(1'b1, ADDR_PEND, 32'h3);
    step();
    chk("low idx", 32'h3, 32'(last_vec));
    chk("auto clr", 32'h2, 32'(pending));
    xfer(1'b1, ADDR_PRIO, 32'h2);
    step();
    chk("preempt", 32'hb, 32'(last_vec));
    chk("nest", 32'h2, 32'(call_cnt - n0));
    chk("src", 32'h1, 32'(call_src));
    $display("priority done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    chk("ready", 32'h1, 32'(hreadyout));
    chk("resp", 32'h0, 32'(hresp));
    xfer(1'b0, ADDR_IE, 32'h0);
    chk("ie rst", 32'h0, rd);
    xfer(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h0, rd);
    xfer(1'b1, ADDR_PEND, 32'h1000);
    xfer(1'b0, ADDR_PEND, 32'h0);
    chk("pend rd", 32'h1000, rd);
    // own enable on, global still off: boundary must not vector
    xfer(1'b1, ADDR_EIE, 32'h20);
    step();
    step();
    chk("no call", 32'h0, 32'(call_cnt));
    chk("req off", 32'h0, 32'(req_pending));
    $display("reset done");
    finish_test();
  end
endmodule
